// [hdl/tmr_device.sv]
`timescale 1ns/1ps
module tmr_device #(
    parameter int unsigned BASE_CYC = tmr_pkg::FAST_INTERVAL_CYC
) (
    tmr_link_if.dev lk,
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic signed [9:0] SENSE_TEMP,
    output logic ALERT_OUT,
    output logic ALERT_OE,
    output logic SHUTDOWN_OUT,
    output logic SHUTDOWN_OE
);

    // ****************************************************************
    // Helper functions.
    // ****************************************************************

    // Converts a signed reading into the register code of the range.
    function automatic logic [7:0] tmr_format(input logic signed [9:0] t, input logic ext);
        logic signed [10:0] v;
        logic signed [10:0] top;
        v = ext ? (11'(t) + tmr_pkg::EXT_OFFSET) : 11'(t);
        top = ext ? tmr_pkg::EXT_MAX : tmr_pkg::BIN_MAX;
        if (v < 11'sd0) begin
            tmr_format = 8'h00;
        end else if (v > top) begin
            tmr_format = top[7:0];
        end else begin
            tmr_format = v[7:0];
        end
    endfunction : tmr_format

    // True once the reading has fallen to the limit minus hysteresis.
    function automatic logic tmr_released(input logic [7:0] t, input logic [7:0] lim,
                                          input logic [7:0] hyst);
        logic signed [9:0] th;
        th = signed'({2'b00, lim}) - signed'({2'b00, hyst});
        tmr_released = signed'({2'b00, t}) <= th;
    endfunction : tmr_released

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [7:0] ptr_q;
    logic [7:0] temp_q;
    logic [7:0] cfg_q;
    logic [7:0] rate_q;
    logic [7:0] high_q;
    logic [7:0] low_q;
    logic [7:0] shut_lim_q;
    logic [7:0] hyst_q;
    logic [7:0] consec_q;
    logic hi_flag_q;
    logic lo_flag_q;
    logic shut_q;
    logic shut2_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic eval_q;
    logic [31:0] cnt_q;
    logic alert_oe_q;
    logic shut_oe_q;
    logic low_level_q;

    logic take;
    logic reg_wr;
    logic status_rd;
    logic standby;
    logic ext_range;
    logic pin_fn;
    logic [3:0] code;
    logic [31:0] interval;
    logic conv_done;
    logic [7:0] status;
    logic hi_cond;
    logic lo_cond;

    assign take = lk.valid & ~ack_q;
    assign reg_wr = take & (lk.op == tmr_pkg::OP_WRITE);
    assign status_rd = take & (lk.op == tmr_pkg::OP_READ) & (ptr_q == tmr_pkg::RD_STATUS);
    assign standby = cfg_q[tmr_pkg::CFG_STANDBY_BIT];
    assign ext_range = cfg_q[tmr_pkg::CFG_RANGE_BIT];
    assign pin_fn = cfg_q[tmr_pkg::CFG_PIN_FUNCTION_SELECT];
    assign hi_cond = temp_q > high_q;
    assign lo_cond = temp_q <= low_q;
    assign status = {1'b0, hi_flag_q, lo_flag_q, 4'h0, shut_q};

    // Reserved rate codes run at the fastest documented rate.
    assign code = (rate_q[3:0] > tmr_pkg::RATE_MAX_CODE) ? tmr_pkg::RATE_MAX_CODE : rate_q[3:0];
    assign interval = BASE_CYC << (tmr_pkg::RATE_MAX_CODE - code);
    assign conv_done = ~standby & (cnt_q >= interval - 32'd1);

    // Read multiplexer over the eleven readable registers.
    function automatic logic [7:0] tmr_read(input logic [7:0] a);
        unique case (a)
            tmr_pkg::RD_TEMP: tmr_read = temp_q;
            tmr_pkg::RD_STATUS: tmr_read = status;
            tmr_pkg::RD_CONFIG: tmr_read = cfg_q;
            tmr_pkg::RD_RATE: tmr_read = rate_q;
            tmr_pkg::RD_HIGH: tmr_read = high_q;
            tmr_pkg::RD_LOW: tmr_read = low_q;
            tmr_pkg::RW_SHUT_LIMIT: tmr_read = shut_lim_q;
            tmr_pkg::RW_HYST: tmr_read = hyst_q;
            tmr_pkg::RW_CONSEC: tmr_read = consec_q;
            tmr_pkg::RD_MAKER_ID: tmr_read = tmr_pkg::MAKER_ID;
            tmr_pkg::RD_REVISION: tmr_read = tmr_pkg::REVISION;
            default: tmr_read = 8'h00;
        endcase
    endfunction : tmr_read

    // ****************************************************************
    // Link handling.
    // ****************************************************************

    // Acknowledges each request for one cycle and returns read data.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else if (CE) begin
            ack_q <= take;
            if (take && lk.op == tmr_pkg::OP_READ) begin
                rdata_q <= tmr_read(ptr_q);
            end
        end
    end

    // The first byte of every write lands in the pointer.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ptr_q <= tmr_pkg::RST_PTR;
        end else if (CE && take && (lk.op == tmr_pkg::OP_PTR || lk.op == tmr_pkg::OP_WRITE)) begin
            ptr_q <= lk.byte0;
        end
    end

    // The second byte of a write goes to the register it addresses.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            cfg_q <= tmr_pkg::RST_CONFIG;
            rate_q <= tmr_pkg::RST_RATE;
            high_q <= tmr_pkg::RST_HIGH;
            low_q <= tmr_pkg::RST_LOW;
            shut_lim_q <= tmr_pkg::RST_SHUT_LIMIT;
            hyst_q <= tmr_pkg::RST_HYST;
            consec_q <= tmr_pkg::RST_CONSEC;
        end else if (CE && reg_wr) begin
            unique case (lk.byte0)
                tmr_pkg::WR_CONFIG: cfg_q <= lk.byte1 & tmr_pkg::CFG_USED_MASK;
                tmr_pkg::WR_RATE: rate_q <= lk.byte1;
                tmr_pkg::WR_HIGH: high_q <= lk.byte1;
                tmr_pkg::WR_LOW: low_q <= lk.byte1;
                tmr_pkg::RW_SHUT_LIMIT: shut_lim_q <= lk.byte1;
                tmr_pkg::RW_HYST: hyst_q <= lk.byte1;
                tmr_pkg::RW_CONSEC: consec_q <= lk.byte1;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Conversion pacing and result.
    // ****************************************************************

    // Interval counter; it holds at zero in standby.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            cnt_q <= 32'h0;
        end else if (CE) begin
            if (standby || conv_done) begin
                cnt_q <= 32'h0;
            end else begin
                cnt_q <= cnt_q + 32'd1;
            end
        end
    end

    // Stores each result in the range selected when it completes.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            temp_q <= tmr_pkg::RST_TEMP;
        end else if (CE && conv_done) begin
            temp_q <= tmr_format(SENSE_TEMP, ext_range);
        end
    end

    // Comparisons run after each result and after standby writes.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            eval_q <= 1'b0;
        end else if (CE) begin
            eval_q <= conv_done | (standby & reg_wr);
        end
    end

    // ****************************************************************
    // Limit comparisons.
    // ****************************************************************

    // Shutdown channels trip above their limit and release with hysteresis.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            shut_q <= 1'b0;
            shut2_q <= 1'b0;
        end else if (CE && eval_q) begin
            if (temp_q > shut_lim_q) begin
                shut_q <= 1'b1;
            end else if (tmr_released(temp_q, shut_lim_q, hyst_q)) begin
                shut_q <= 1'b0;
            end
            if (hi_cond) begin
                shut2_q <= 1'b1;
            end else if (tmr_released(temp_q, high_q, hyst_q)) begin
                shut2_q <= 1'b0;
            end
        end
    end

    // Violation flags latch; a status read clears them once in limit.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            hi_flag_q <= 1'b0;
            lo_flag_q <= 1'b0;
        end else if (CE) begin
            if (eval_q && !pin_fn && hi_cond) begin
                hi_flag_q <= 1'b1;
            end else if (status_rd && !hi_cond) begin
                hi_flag_q <= 1'b0;
            end
            if (eval_q && !pin_fn && lo_cond) begin
                lo_flag_q <= 1'b1;
            end else if (status_rd && !lo_cond) begin
                lo_flag_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Open-drain pins.
    // ****************************************************************

    // Drives each pin low while its alarm is active.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            alert_oe_q <= 1'b0;
            shut_oe_q <= 1'b0;
            low_level_q <= 1'b0;
        end else if (CE) begin
            alert_oe_q <= pin_fn ? shut2_q :
                ((hi_flag_q | lo_flag_q) & ~cfg_q[tmr_pkg::CFG_ALERT_SUPPRESS_BIT]);
            shut_oe_q <= shut_q;
            low_level_q <= 1'b0;
        end
    end

    assign lk.ack = ack_q;
    assign lk.rdata = rdata_q;
    assign ALERT_OUT = low_level_q;
    assign ALERT_OE = alert_oe_q;
    assign SHUTDOWN_OUT = low_level_q;
    assign SHUTDOWN_OE = shut_oe_q;

endmodule : tmr_device

// [hdl/tmr_host.sv]
`timescale 1ns/1ps
module tmr_host (
    tmr_link_if.host lk,
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // ****************************************************************
    // State and registers.
    // ****************************************************************
    typedef enum logic [0:0] {
        H_IDLE = 1'b0,
        H_WAIT = 1'b1
    } tmr_hstate_e;

    tmr_hstate_e state_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic valid_q;
    tmr_pkg::tmr_op_e op_q;
    logic [7:0] byte0_q;
    logic [7:0] byte1_q;
    logic [7:0] rd_q;
    logic access;
    logic done;
    logic mapped;
    logic cmd_wr;

    assign access = PSEL & PENABLE & ~pready_q;
    assign done = PSEL & PENABLE & pready_q;
    assign mapped = (PADDR == tmr_pkg::HOST_CMD) | (PADDR == tmr_pkg::HOST_STAT);
    assign cmd_wr = done & PWRITE & (PADDR == tmr_pkg::HOST_CMD) & (state_q == H_IDLE);

    // ****************************************************************
    // APB slave.
    // ****************************************************************

    // Answers every access after one wait state.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (CE) begin
            pready_q <= access;
            pslverr_q <= access & ~mapped;
            if (access && !PWRITE && PADDR == tmr_pkg::HOST_STAT) begin
                prdata_q <= {16'h0, rd_q, 7'h0, state_q == H_WAIT};
            end else if (access && !PWRITE && PADDR == tmr_pkg::HOST_CMD) begin
                prdata_q <= {14'h0, op_q, byte1_q, byte0_q};
            end else begin
                prdata_q <= 32'h0;
            end
        end
    end

    // ****************************************************************
    // Link master.
    // ****************************************************************

    // Holds a request until the monitor acknowledges it.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state_q <= H_IDLE;
            valid_q <= 1'b0;
            op_q <= tmr_pkg::OP_NONE;
            byte0_q <= 8'h00;
            byte1_q <= 8'h00;
            rd_q <= 8'h00;
        end else if (CE) begin
            unique case (state_q)
                H_IDLE: begin
                    if (cmd_wr) begin
                        op_q <= tmr_pkg::tmr_op_e'(PWDATA[tmr_pkg::CMD_OP_LSB +: 2]);
                        byte0_q <= PWDATA[tmr_pkg::CMD_ADDR_LSB +: 8];
                        byte1_q <= PWDATA[tmr_pkg::CMD_DATA_LSB +: 8];
                        valid_q <= 1'b1;
                        state_q <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (lk.ack) begin
                        valid_q <= 1'b0;
                        if (op_q == tmr_pkg::OP_READ) begin
                            rd_q <= lk.rdata;
                        end
                        state_q <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign lk.valid = valid_q;
    assign lk.op = op_q;
    assign lk.byte0 = byte0_q;
    assign lk.byte1 = byte1_q;
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;

endmodule : tmr_host

// [hdl/tmr_link_if.sv]
`timescale 1ns/1ps
// Byte-level register link between the host controller and the monitor.
interface tmr_link_if;
    logic valid;
    tmr_pkg::tmr_op_e op;
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic ack;
    logic [7:0] rdata;

    modport dev (input valid, input op, input byte0, input byte1, output ack, output rdata);
    modport host (output valid, output op, output byte0, output byte1, input ack, input rdata);
endinterface : tmr_link_if

// [hdl/tmr_pkg.sv]
// Operation
// - Binary default range, offset-by-64 extended range.
// - Default range clamps results to 0..127 degrees.
// - Next result after range change uses new format.
// - Write byte one loads pointer, byte two data.
// - Pointer powers up zero, reads return temperature.
// - Temperature register read-only, converter-written, resets zero.
// - Configuration read 0x03, written 0x09, resets zero.
// - Bit 7 masks alert unless secondary shutdown.
// - Bit 6 stops conversions; bus, outputs stay active.
// - Standby register writes re-evaluate alarm outputs.
// - Bit 5 selects alert or secondary shutdown.
// - Bit 2 selects default or extended range.
// - Rate read 0x04, written 0x0A, low nibble.
// - Codes 0..10 halve interval; above reserved.
// - Rate resets to 0x08; host keeps upper nibble zero.
// - High trips on greater, low on less-or-equal.
// - Shutdown above its limit; secondary above high.
// - One hysteresis for both shutdowns, resets 10.
// - Host rewrites limits after a range change.
// - Limits and hysteresis are readable and writable.
// - Twelve eight-bit registers in total.
// - Shutdown releases at limit minus hysteresis.
// - Violation flags latch alert; status read clears.
package tmr_pkg;

    // ****************************************************************
    // Register addresses on the link.
    // ****************************************************************
    localparam logic [7:0] RD_TEMP = 8'h00;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_RATE = 8'h04;
    localparam logic [7:0] RD_HIGH = 8'h05;
    localparam logic [7:0] RD_LOW = 8'h06;
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_RATE = 8'h0a;
    localparam logic [7:0] WR_HIGH = 8'h0b;
    localparam logic [7:0] WR_LOW = 8'h0c;
    localparam logic [7:0] RW_SHUT_LIMIT = 8'h20;
    localparam logic [7:0] RW_HYST = 8'h21;
    localparam logic [7:0] RW_CONSEC = 8'h22;
    localparam logic [7:0] RD_MAKER_ID = 8'hfe;
    localparam logic [7:0] RD_REVISION = 8'hff;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [7:0] RST_PTR = 8'h00;
    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h08;
    localparam logic [7:0] RST_HIGH = 8'h55;
    localparam logic [7:0] RST_LOW = 8'h00;
    localparam logic [7:0] RST_SHUT_LIMIT = 8'h55;
    localparam logic [7:0] RST_HYST = 8'h0a;
    localparam logic [7:0] RST_CONSEC = 8'h01;
    // Identification values are arbitrary.
    localparam logic [7:0] MAKER_ID = 8'h5a;
    localparam logic [7:0] REVISION = 8'h01;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int CFG_ALERT_SUPPRESS_BIT = 7;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int CFG_PIN_FUNCTION_SELECT = 5;
    localparam int CFG_RANGE_BIT = 2;
    localparam logic [7:0] CFG_USED_MASK = 8'he4;
    localparam int ST_HIGH_BIT = 6;
    localparam int ST_LOW_BIT = 5;
    localparam int ST_SHUT_BIT = 0;

    // ****************************************************************
    // Data format.
    // ****************************************************************
    localparam logic signed [10:0] EXT_OFFSET = 11'sd64;
    localparam logic signed [10:0] BIN_MAX = 11'sd127;
    localparam logic signed [10:0] EXT_MAX = 11'sd255;

    // ****************************************************************
    // Conversion pacing.
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int FAST_INTERVAL_NS = 15_500_000;
    localparam int FAST_INTERVAL_CYC = FAST_INTERVAL_NS / CLK_PERIOD_NS;
    localparam logic [3:0] RATE_MAX_CODE = 4'h a;

    // ****************************************************************
    // Link operations.
    // ****************************************************************
    typedef enum logic [1:0] {
        OP_PTR = 2'h0,
        OP_WRITE = 2'h1,
        OP_READ = 2'h2,
        OP_NONE = 2'h3
    } tmr_op_e;

    // ****************************************************************
    // Host command port.
    // ****************************************************************
    localparam logic [7:0] HOST_CMD = 8'h00;
    localparam logic [7:0] HOST_STAT = 8'h04;
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_OP_LSB = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DATA_LSB = 8;

endpackage : tmr_pkg

// [testbench/temp_monitor_regs_limits_tb.sv]
`timescale 1ns/1ps
module temp_monitor_regs_limits_tb;
    // ****************************************************************
    // Stimulus, design ends and checker.
    // ****************************************************************
    localparam logic [7:0] WA [6] = '{8'h0b, 8'h0c, 8'h20, 8'h21, 8'h0a, 8'h09};
    localparam logic [7:0] RA [6] = '{8'h05, 8'h06, 8'h20, 8'h21, 8'h04, 8'h03};
    localparam logic [7:0] RV [6] = '{8'h55, 8'h00, 8'h55, 8'h0a, 8'h08, 8'h00};
    localparam logic [7:0] WV [6] = '{8'h32, 8'h14, 8'h3c, 8'h05, 8'h0a, 8'h04};
    localparam logic [7:0] EV [6] = '{8'h32, 8'h14, 8'h3c, 8'h05, 8'h0a, 8'h04};
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [9:0] sense = 10'sd0;
    logic alert_oe;
    logic shut_oe;
    logic alert_out;
    logic shut_out;
    logic [31:0] word;
    logic [7:0] rd;
    logic err;
    int error_cnt = 0;
    int samples_checked = 0;

    tmr_link_if lk ();
    tmr_host tmr_host_inst (.lk(lk), .REF_CLK(ref_clk), .RESET_N(reset_n), .CE(1'b1),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    tmr_device #(.BASE_CYC(20)) tmr_device_inst (.lk(lk), .REF_CLK(ref_clk),
        .RESET_N(reset_n), .CE(1'b1), .SENSE_TEMP(sense), .ALERT_OUT(alert_out),
        .ALERT_OE(alert_oe), .SHUTDOWN_OUT(shut_out), .SHUTDOWN_OE(shut_oe));
    tmr_link_props tmr_link_props_inst (.REF_CLK(ref_clk), .RESET_N(reset_n),
        .valid(lk.valid), .op(lk.op), .byte0(lk.byte0), .byte1(lk.byte1), .ack(lk.ack),
        .rdata(lk.rdata));

    // Clock at 200 MHz.
    always #2.5 ref_clk = ~ref_clk;

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // Compares one byte and reports a mismatch at once.
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        word = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
    endtask : apb

    // Issues one link operation and waits until the controller is idle.
    task automatic link(input tmr_pkg::tmr_op_e op, input logic [7:0] a, input logic [7:0] d);
        int n;
        apb(1'b1, tmr_pkg::HOST_CMD, {14'h0, op, d, a});
        n = 0;
        do begin
            apb(1'b0, tmr_pkg::HOST_STAT, 32'h0);
            n++;
        end while (word[tmr_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 20);
        rd = word[15:8];
        if (word[tmr_pkg::STAT_BUSY_BIT] !== 1'b0) begin
            error_cnt++;
            end_sim();
        end
    endtask : link

    // Register read: pointer load, then a read at the pointer.
    task automatic rdreg(input logic [7:0] a);
        link(tmr_pkg::OP_PTR, a, 8'h00);
        link(tmr_pkg::OP_READ, 8'h00, 8'h00);
    endtask : rdreg

    // Sets the sensed temperature and lets several conversions pass.
    task automatic heat(input int t);
        @(posedge ref_clk);
        sense <= 10'(t);
        repeat (80) @(posedge ref_clk);
    endtask : heat

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    // Reset values, read without pointer write, unmapped host address.
    task automatic t_defaults();
        link(tmr_pkg::OP_READ, 8'h00, 8'h00);
        check("temperature at reset pointer", 8'h00, rd);
        for (int i = 0; i < 6; i++) begin
            rdreg(RA[i]);
            check("register reset value", RV[i], rd);
        end
        apb(1'b0, 8'h08, 32'h0);
        check("unmapped slave error", 8'h01, {7'h0, err});
    endtask : t_defaults

    // Write then read back; config range bit and read-only temperature.
    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            link(tmr_pkg::OP_WRITE, WA[i], WV[i]);
            rdreg(RA[i]);
            check("register readback", EV[i], rd);
        end
        link(tmr_pkg::OP_WRITE, 8'h00, 8'h77);
        rdreg(tmr_pkg::RD_TEMP);
        check("read-only temperature", 8'h40, rd);
    endtask : t_regs

    // Extended range first (left selected above), then the default range.
    task automatic t_formats();
        int tv [3] = '{-55, 25, 150};
        logic [7:0] ex [3] = '{8'h09, 8'h59, 8'hd6};
        logic [7:0] bx [3] = '{8'h00, 8'h19, 8'h7f};
        for (int r = 0; r < 2; r++) begin
            link(tmr_pkg::OP_WRITE, tmr_pkg::WR_CONFIG, r == 0 ? 8'h04 : 8'h00);
            for (int i = 0; i < 3; i++) begin
                heat(tv[i]);
                rdreg(tmr_pkg::RD_TEMP);
                check("temperature code", r == 0 ? ex[i] : bx[i], rd);
            end
        end
    endtask : t_formats

    // Limits: high 50, low 20, shutdown 60, hysteresis 5.
    task automatic t_alarms();
        link(tmr_pkg::OP_WRITE, tmr_pkg::WR_HIGH, 8'h32);
        heat(30);
        rdreg(tmr_pkg::RD_STATUS);
        check("alert idle", 8'h00, {7'h0, alert_oe});
        heat(51);
        check("alert above high", 8'h01, {7'h0, alert_oe});
        heat(50);
        check("alert latched", 8'h01, {7'h0, alert_oe});
        rdreg(tmr_pkg::RD_STATUS);
        check("status high flag", 8'h40, rd);
        repeat (4) @(posedge ref_clk);
        check("alert cleared", 8'h00, {7'h0, alert_oe});
        link(tmr_pkg::OP_WRITE, tmr_pkg::WR_CONFIG, 8'h80);
        heat(51);
        check("alert masked", 8'h00, {7'h0, alert_oe});
        heat(30);
        rdreg(tmr_pkg::RD_STATUS);
        link(tmr_pkg::OP_WRITE, tmr_pkg::WR_CONFIG, 8'h00);
        heat(21);
        check("alert just above low", 8'h00, {7'h0, alert_oe});
        heat(20);
        check("alert at low limit", 8'h01, {7'h0, alert_oe});
        heat(61);
        check("shutdown above limit", 8'h01, {7'h0, shut_oe});
        check("pin drive levels", 8'h00, {6'h0, alert_out, shut_out});
        heat(56);
        check("shutdown in hysteresis", 8'h01, {7'h0, shut_oe});
        heat(55);
        check("shutdown released", 8'h00, {7'h0, shut_oe});
        link(tmr_pkg::OP_WRITE, tmr_pkg::WR_CONFIG, 8'ha0);
        heat(51);
        check("secondary above high", 8'h01, {7'h0, alert_oe});
        heat(46);
        check("secondary in hysteresis", 8'h01, {7'h0, alert_oe});
        heat(45);
        check("secondary released", 8'h00, {7'h0, alert_oe});
        link(tmr_pkg::OP_WRITE, tmr_pkg::WR_CONFIG, 8'h60);
        heat(51);
        check("standby pin", 8'h00, {7'h0, alert_oe});
        rdreg(tmr_pkg::RD_TEMP);
        check("standby holds result", 8'h2d, rd);
        link(tmr_pkg::OP_WRITE, tmr_pkg::WR_HIGH, 8'h28);
        repeat (4) @(posedge ref_clk);
        check("standby re-evaluation", 8'h01, {7'h0, alert_oe});
        link(tmr_pkg::OP_WRITE, tmr_pkg::WR_CONFIG, 8'h20);
        heat(51);
        rdreg(tmr_pkg::RD_TEMP);
        check("conversion resumed", 8'h33, rd);
    endtask : t_alarms

    // Main sequence: reset for 20 cycles, then the scenarios.
    initial begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_defaults();
        t_regs();
        t_formats();
        t_alarms();
        end_sim();
    end
endmodule : temp_monitor_regs_limits_tb

// [testbench/tmr_link_props.sv]
`timescale 1ns/1ps
// ****************************************************************
// Link handshake checks between host controller and monitor.
// ****************************************************************
module tmr_link_props (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic valid,
    input wire tmr_pkg::tmr_op_e op,
    input wire logic [7:0] byte0,
    input wire logic [7:0] byte1,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    // All checks share the one clock and its reset.
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);

    // Handshake timing and request stability.
    a_ack_after_take: assert property (valid && !ack |=> ack)
        else $error("ack did not follow a taken request");
    a_ack_one_cycle: assert property (ack |=> !ack)
        else $error("ack stood longer than one cycle");
    a_ack_needs_req: assert property (ack |-> valid && $past(valid))
        else $error("ack without a standing request");
    a_valid_drops: assert property (ack |=> !valid)
        else $error("valid held after ack");
    a_req_held_stable:
        assert property (valid && !ack |=> valid && $stable(op) && $stable(byte0)
            && $stable(byte1)) else $error("request changed before ack");
    a_gap_after_fall: assert property ($fell(valid) |=> !valid)
        else $error("request gap too short");
    a_rdata_on_ack: assert property (!$stable(rdata) |-> ack)
        else $error("read data changed without ack");
    a_take_no_ack: assert property ($rose(valid) |-> !ack)
        else $error("ack present as request rose");
endmodule : tmr_link_props
